/* hw/vga_front_end.sv */
`timescale 1ns/1ns
// Behaviour
// - host memory A0000h..BFFFFh (128 KB) is the candidate display window.
// - EGA/VGA mapping decodes A0000h..AFFFFh as display memory.
// - monochrome mapping decodes B0000h..B7FFFh as display memory.
// - colour text mapping decodes B8000h..BFFFFh as display memory.
// - I/O ports 3B0h..3DFh reach the display control registers.
// - registers are reached by writing an index, then accessing data.
// - some registers answer at a mono or a colour location.
// - display memory is 256 KB as 64K words of 32 bits.
// - each plane is one byte lane of every word, plane 0 lowest.
// - memory addresses step by whole 32-bit words.
// - byte selection exists only for writes, via four per-plane enables.
// - one word yields eight 4-bit pixels, leftmost from bit 7, plane 3 MSB.
// - the CPU side of read and write paths moves one byte per operation.
// - 16 and 32-bit accesses split into byte operations at rising addresses.
// - front-end and refresh controls are separate fields.
// - detected accesses to emulated hardware raise the management interrupt.
// - display accesses are served inside and make no external bus cycle.
// - host address bits 15..0 form the word address, subject to chaining.
// - odd/even writes enable lanes 0,2 for bit 0 low, else lanes 1,3.
// - the plane write mask is ANDed with address-derived enables.
module vga_front_end (
  input  wire logic                  sys_clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  req_valid_i,
  input  wire logic                  req_io_i,
  input  wire logic                  req_write_i,
  input  wire logic [31:0]           req_addr_i,
  input  wire vga_fe_pkg::acc_size_t req_size_i,
  input  wire logic [31:0]           req_wdata_i,
  input  wire logic                  trap_mem_i,
  input  wire logic                  trap_io_i,
  input  wire logic                  mgmt_ack_i,
  output logic                       busy_o,
  output logic                       ack_o,
  output logic                       pass_o,
  output logic [31:0]                rdata_o,
  output logic                       mgmt_interrupt_request_o,
  output logic [31:0]                pixels_o
);
  import vga_fe_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_MEM, ST_RDWAIT, ST_IO, ST_DONE
  } state_t;

  state_t      state_q;
  logic        io_q;
  logic        write_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [1:0]  last_q;
  logic [1:0]  cnt_q;
  logic [31:0] rdata_q;
  logic        ack_q;
  logic        pass_q;
  logic        busy_q;
  logic        smi_q;
  logic [31:0] pixels_q;

  logic [7:0]  misc_q;
  logic [7:0]  seq_idx_q;
  logic [7:0]  gfx_idx_q;
  logic [7:0]  crt_idx_q;
  logic [3:0]  plane_write_mask_q;
  logic [7:0]  mem_mode_q;
  logic [1:0]  read_map_q;
  logic [7:0]  gfx_misc_q;
  logic [7:0]  crt_q [CRT_REGS];

  logic [31:0] cur_addr;
  logic        win_hit;
  map_sel_t    map_sel;
  logic        chain4;
  logic        odd_even;
  logic [15:0] mem_addr;
  logic [3:0]  lane_en;
  logic [1:0]  rd_plane;
  logic        mem_wr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [7:0]  rd_byte;
  logic [15:0] io_addr;
  logic        io_hit;
  logic        crt_here;
  logic [7:0]  io_wbyte;
  logic [7:0]  io_rbyte;
  logic [31:0] pix_word;

  assign map_sel  = map_sel_t'(gfx_misc_q[GMISC_MAP_LSB +: 2]);
  assign chain4   = mem_mode_q[MMODE_CHAIN4_BIT];
  assign odd_even = ~mem_mode_q[MMODE_OEDIS_BIT] & ~chain4;

  // byte operation i works on access address plus i
  assign cur_addr = addr_q + {30'h0000_0000, cnt_q};

  function automatic logic in_window(input logic [31:0] a, input map_sel_t m);
    logic hit;
    hit = 1'b0;
    case (m)
      MAP_ALL: hit = (a >= WIN_BASE) && (a <= WIN_LAST);
      MAP_EGA: hit = (a >= EGA_BASE) && (a <= EGA_LAST);
      MAP_MDA: hit = (a >= MDA_BASE) && (a <= MDA_LAST);
      MAP_CGA: hit = (a >= CGA_BASE) && (a <= CGA_LAST);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  assign win_hit = in_window(req_addr_i, map_sel);

  // address translation for the byte now in flight
  always_comb begin
    mem_addr = cur_addr[15:0];
    lane_en  = plane_write_mask_q;
    rd_plane = read_map_q;
    if (chain4) begin
      mem_addr = {cur_addr[15:2], 2'b00};
      lane_en  = plane_write_mask_q & (4'h1 << cur_addr[1:0]);
      rd_plane = cur_addr[1:0];
    end else if (odd_even) begin
      mem_addr = {cur_addr[15:1], misc_q[MISC_PAGE_BIT]};
      lane_en  = plane_write_mask_q & (cur_addr[0] ? 4'hA : 4'h5);
      rd_plane = {read_map_q[1], cur_addr[0]};
    end
  end

  // the CPU byte goes to every lane; the enables pick the planes
  assign mem_wr    = (state_q == ST_MEM) && write_q;
  assign mem_wdata = {4{wdata_q[cnt_q*8 +: 8]}};

  vga_plane_mem u_mem (
    .sys_clk_i   (sys_clk_i),
    .ce_i        (ce_i),
    .wr_i        (mem_wr),
    .lane_en_i   (lane_en),
    .word_addr_i (mem_addr),
    .wdata_i     (mem_wdata),
    .rdata_o     (mem_rdata)
  );

  assign rd_byte = mem_rdata[rd_plane*8 +: 8];

  // eight pixels, pixel 0 leftmost in bits 3:0
  for (genvar i = 0; i < 8; i++) begin : g_pix
    for (genvar j = 0; j < 4; j++) begin : g_bit
      assign pix_word[i*4 + j] = mem_rdata[j*8 + (7 - i)];
    end
  end

  // crtc answers only at the location chosen by the io select bit
  assign io_addr  = addr_q[15:0];
  assign io_hit   = (req_addr_i[15:0] >= IO_FIRST) && (req_addr_i[15:0] <= IO_LAST);
  assign crt_here = misc_q[MISC_IOSEL_BIT] ?
                    (io_addr == IO_CRT_IDX_C || io_addr == IO_CRT_DAT_C) :
                    (io_addr == IO_CRT_IDX_M || io_addr == IO_CRT_DAT_M);
  assign io_wbyte = wdata_q[7:0];

  always_comb begin
    io_rbyte = IO_IDLE_DATA;
    if (io_addr == IO_MISC_RD) begin
      io_rbyte = misc_q;
    end else if (io_addr == IO_SEQ_IDX) begin
      io_rbyte = seq_idx_q;
    end else if (io_addr == IO_SEQ_DAT) begin
      if (seq_idx_q == SEQ_MAP_MASK) begin
        io_rbyte = {4'h0, plane_write_mask_q};
      end else if (seq_idx_q == SEQ_MEM_MODE) begin
        io_rbyte = mem_mode_q;
      end else begin
        io_rbyte = 8'h00;
      end
    end else if (io_addr == IO_GFX_IDX) begin
      io_rbyte = gfx_idx_q;
    end else if (io_addr == IO_GFX_DAT) begin
      if (gfx_idx_q == GFX_READ_MAP) begin
        io_rbyte = {6'h00, read_map_q};
      end else if (gfx_idx_q == GFX_MISC) begin
        io_rbyte = gfx_misc_q;
      end else begin
        io_rbyte = 8'h00;
      end
    end else if (crt_here && !io_addr[0]) begin
      io_rbyte = crt_idx_q;
    end else if (crt_here) begin
      io_rbyte = crt_q[crt_idx_q[4:0]];
    end
  end

  // access sequencing
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      io_q    <= 1'b0;
      write_q <= 1'b0;
      addr_q  <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      last_q  <= 2'b00;
      cnt_q   <= 2'b00;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE: begin
          if (req_valid_i) begin
            io_q    <= req_io_i;
            write_q <= req_write_i;
            addr_q  <= req_addr_i;
            wdata_q <= req_wdata_i;
            cnt_q   <= 2'b00;
            case (req_size_i)
              SZ_WORD:  last_q <= 2'd1;
              SZ_DWORD: last_q <= 2'd3;
              default:  last_q <= 2'd0;
            endcase
            if (req_io_i && io_hit) begin
              state_q <= ST_IO;
            end else if (!req_io_i && win_hit) begin
              state_q <= ST_MEM;
            end
          end
        end
        ST_MEM: begin
          if (!write_q) begin
            state_q <= ST_RDWAIT;
          end else if (cnt_q == last_q) begin
            state_q <= ST_DONE;
          end else begin
            cnt_q <= cnt_q + 2'd1;
          end
        end
        ST_RDWAIT: begin
          if (cnt_q == last_q) begin
            state_q <= ST_DONE;
          end else begin
            cnt_q   <= cnt_q + 2'd1;
            state_q <= ST_MEM;
          end
        end
        ST_IO: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // host answer: ack after the last byte operation, or at once for an unclaimed port
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q   <= 1'b0;
      pass_q  <= 1'b0;
      busy_q  <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q  <= (state_q == ST_DONE) || ((state_q == ST_IDLE) && req_valid_i &&
                req_io_i && !io_hit);
      // claimed accesses never reach the outside bus
      pass_q <= (state_q == ST_IDLE) && req_valid_i && !req_io_i && !win_hit;
      busy_q <= (state_q == ST_IDLE) ? (req_valid_i && (io_hit || win_hit) &&
                (req_io_i ? io_hit : win_hit)) : (state_q != ST_DONE);
      if (state_q == ST_IDLE && req_valid_i) begin
        rdata_q <= req_io_i ? {24'h00_0000, IO_IDLE_DATA} : 32'h0000_0000;
      end else if (state_q == ST_RDWAIT) begin
        rdata_q[cnt_q*8 +: 8] <= rd_byte;
      end else if (state_q == ST_IO && !write_q) begin
        rdata_q <= {24'h00_0000, io_rbyte};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pixels_q <= 32'h0000_0000;
    end else if (ce_i && state_q == ST_RDWAIT) begin
      pixels_q <= pix_word;
    end
  end

  // front-end controls; crtc values feed only the io read-back path
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      misc_q             <= MISC_RESET;
      seq_idx_q          <= 8'h00;
      gfx_idx_q          <= 8'h00;
      crt_idx_q          <= 8'h00;
      plane_write_mask_q <= MASK_RESET;
      mem_mode_q         <= MMODE_RESET;
      read_map_q         <= 2'b00;
      gfx_misc_q         <= GMISC_RESET;
    end else if (ce_i && state_q == ST_IO && write_q) begin
      if (io_addr == IO_MISC_WR) begin
        misc_q <= io_wbyte;
      end else if (io_addr == IO_SEQ_IDX) begin
        seq_idx_q <= io_wbyte;
      end else if (io_addr == IO_SEQ_DAT) begin
        if (seq_idx_q == SEQ_MAP_MASK) begin
          plane_write_mask_q <= io_wbyte[3:0];
        end else if (seq_idx_q == SEQ_MEM_MODE) begin
          mem_mode_q <= io_wbyte;
        end
      end else if (io_addr == IO_GFX_IDX) begin
        gfx_idx_q <= io_wbyte;
      end else if (io_addr == IO_GFX_DAT) begin
        if (gfx_idx_q == GFX_READ_MAP) begin
          read_map_q <= io_wbyte[1:0];
        end else if (gfx_idx_q == GFX_MISC) begin
          gfx_misc_q <= io_wbyte;
        end
      end else if (crt_here && !io_addr[0]) begin
        crt_idx_q <= io_wbyte;
      end
    end
  end

  // kept apart from every front-end field
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 0; k < CRT_REGS; k++) begin
        crt_q[k] <= 8'h00;
      end
    end else if (ce_i && state_q == ST_IO && write_q && crt_here && io_addr[0]) begin
      crt_q[crt_idx_q[4:0]] <= io_wbyte;
    end
  end

  // trap request: a new detection beats a same-cycle acknowledge
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smi_q <= 1'b0;
    end else if (ce_i) begin
      if ((state_q == ST_IO && trap_io_i) ||
          (state_q == ST_MEM && cnt_q == 2'd0 && trap_mem_i)) begin
        smi_q <= 1'b1;
      end else if (mgmt_ack_i) begin
        smi_q <= 1'b0;
      end
    end
  end

  assign busy_o                   = busy_q;
  assign ack_o                    = ack_q;
  assign pass_o                   = pass_q;
  assign rdata_o                  = rdata_q;
  assign mgmt_interrupt_request_o = smi_q;
  assign pixels_o                 = pixels_q;
endmodule

/* hw/vga_fe_pkg.sv */
package vga_fe_pkg;
  localparam logic [31:0] WIN_BASE     = 32'h000A_0000;
  localparam logic [31:0] WIN_LAST     = 32'h000B_FFFF;
  localparam logic [31:0] EGA_BASE     = 32'h000A_0000;
  localparam logic [31:0] EGA_LAST     = 32'h000A_FFFF;
  localparam logic [31:0] MDA_BASE     = 32'h000B_0000;
  localparam logic [31:0] MDA_LAST     = 32'h000B_7FFF;
  localparam logic [31:0] CGA_BASE     = 32'h000B_8000;
  localparam logic [31:0] CGA_LAST     = 32'h000B_FFFF;

  localparam logic [15:0] IO_FIRST     = 16'h03B0;
  localparam logic [15:0] IO_LAST      = 16'h03DF;
  localparam logic [15:0] IO_MISC_WR   = 16'h03C2;
  localparam logic [15:0] IO_MISC_RD   = 16'h03CC;
  localparam logic [15:0] IO_SEQ_IDX   = 16'h03C4;
  localparam logic [15:0] IO_SEQ_DAT   = 16'h03C5;
  localparam logic [15:0] IO_GFX_IDX   = 16'h03CE;
  localparam logic [15:0] IO_GFX_DAT   = 16'h03CF;
  localparam logic [15:0] IO_CRT_IDX_M = 16'h03B4;
  localparam logic [15:0] IO_CRT_DAT_M = 16'h03B5;
  localparam logic [15:0] IO_CRT_IDX_C = 16'h03D4;
  localparam logic [15:0] IO_CRT_DAT_C = 16'h03D5;

  localparam logic [7:0]  SEQ_MAP_MASK = 8'h02;
  localparam logic [7:0]  SEQ_MEM_MODE = 8'h04;
  localparam logic [7:0]  GFX_READ_MAP = 8'h04;
  localparam logic [7:0]  GFX_MISC     = 8'h06;
  localparam int          CRT_REGS     = 32;

  localparam int          MISC_IOSEL_BIT  = 0;
  localparam int          MISC_PAGE_BIT   = 5;
  localparam int          MMODE_OEDIS_BIT = 2;
  localparam int          MMODE_CHAIN4_BIT = 3;
  localparam int          GMISC_MAP_LSB   = 2;

  localparam logic [7:0]  MISC_RESET   = 8'h00;
  localparam logic [3:0]  MASK_RESET   = 4'hF;
  localparam logic [7:0]  MMODE_RESET  = 8'h04;
  localparam logic [7:0]  GMISC_RESET  = 8'h00;
  localparam logic [7:0]  IO_IDLE_DATA = 8'hFF;

  localparam int          MEM_WORDS    = 65536;
  localparam int          MEM_AW       = 16;

  typedef enum logic [1:0] {
    MAP_ALL, MAP_EGA, MAP_MDA, MAP_CGA
  } map_sel_t;

  typedef enum logic [1:0] {
    SZ_BYTE, SZ_WORD, SZ_DWORD
  } acc_size_t;
endpackage

/* hw/vga_plane_mem.sv */
`timescale 1ns/1ns
module vga_plane_mem (
  input  wire logic        sys_clk_i,
  input  wire logic        ce_i,
  input  wire logic        wr_i,
  input  wire logic [3:0]  lane_en_i,
  input  wire logic [15:0] word_addr_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o
);
  import vga_fe_pkg::*;

  // one byte lane per plane, plane 0 in the low byte
  // each plane owns its array so that no variable has two writers
  for (genvar p = 0; p < 4; p++) begin : g_plane
    logic [7:0] plane_q [MEM_WORDS];
    logic [7:0] byte_q;
    always_ff @(posedge sys_clk_i) begin
      if (ce_i) begin
        if (wr_i && lane_en_i[p]) begin
          plane_q[word_addr_i] <= wdata_i[p*8 +: 8];
        end
        byte_q <= plane_q[word_addr_i];
      end
    end
    assign rdata_o[p*8 +: 8] = byte_q;
  end
endmodule

/* verification/vga_front_end_monitor.sv */
`timescale 1ns/1ns
module vga_front_end_monitor
  import vga_fe_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  input  wire logic        req_valid_i,
  input  wire logic        req_io_i,
  input  wire logic        req_write_i,
  input  wire logic [31:0] req_addr_i,
  input  wire acc_size_t   req_size_i,
  input  wire logic        mgmt_ack_i,
  input  wire logic        busy_o,
  input  wire logic        ack_o,
  input  wire logic        pass_o,
  input  wire logic [31:0] rdata_o,
  input  wire logic        mgmt_interrupt_request_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic take;
  logic in_io;
  logic in_win;
  // only valid for hosts that pulse one request and wait for its answer
  assign take   = req_valid_i && ce_i && !busy_o && !ack_o && !pass_o;
  assign in_io  = req_addr_i[15:0] >= IO_FIRST && req_addr_i[15:0] <= IO_LAST;
  assign in_win = req_addr_i >= WIN_BASE && req_addr_i <= WIN_LAST;
  sequence mem_take;
    take && !req_io_i;
  endsequence
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  AST_ACK_PASS: assert property (!(ack_o && pass_o)) else $error("ack and pass together");
  AST_IO_OUT: assert property (take && req_io_i && !in_io |=> ack_o && rdata_o[7:0] == 8'hFF)
    else $error("unclaimed port not answered with FF");
  AST_IO_IN: assert property (take && req_io_i && in_io |=> !ack_o [*2] ##1 ack_o)
    else $error("claimed port answer time wrong");
  AST_MEM_OUT: assert property (mem_take ##0 !in_win |=> pass_o && !ack_o)
    else $error("memory outside window not passed");
  AST_WR_BYTE: assert property (mem_take ##0 req_write_i && req_size_i == SZ_BYTE
    |=> pass_o or (!ack_o [*2] ##1 ack_o)) else $error("byte write time wrong");
  AST_WR_DWORD: assert property (mem_take ##0 req_write_i && req_size_i == SZ_DWORD
    |=> pass_o or (!ack_o [*5] ##1 ack_o)) else $error("dword write time wrong");
  AST_RD_DWORD: assert property (mem_take ##0 !req_write_i && req_size_i == SZ_DWORD
    |=> pass_o or (!ack_o [*8] ##1 !ack_o ##1 ack_o)) else $error("dword read time wrong");
  AST_BUSY_END: assert property ($fell(busy_o) |-> ack_o) else $error("busy ended without ack");
  AST_MGMT_HOLD: assert property (mgmt_interrupt_request_o && !mgmt_ack_i
    |=> mgmt_interrupt_request_o) else $error("management request dropped");
  COV_IO: cover property (take && req_io_i && in_io);
  COV_PASS: cover property (pass_o);
  COV_MGMT: cover property ($rose(mgmt_interrupt_request_o));
endmodule

bind vga_front_end vga_front_end_monitor u_mon (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .ce_i(ce_i), .req_valid_i(req_valid_i), .req_io_i(req_io_i), .req_write_i(req_write_i),
  .req_addr_i(req_addr_i), .req_size_i(req_size_i), .mgmt_ack_i(mgmt_ack_i),
  .busy_o(busy_o), .ack_o(ack_o), .pass_o(pass_o), .rdata_o(rdata_o),
  .mgmt_interrupt_request_o(mgmt_interrupt_request_o));

/* verification/vga_host_model.sv */
`timescale 1ns/1ns
module vga_host_model (
  input  wire logic                  sys_clk_i,
  input  wire logic                  ack_i,
  input  wire logic                  pass_i,
  output logic                       req_valid_o,
  output logic                       req_io_o,
  output logic                       req_write_o,
  output logic [31:0]                req_addr_o,
  output vga_fe_pkg::acc_size_t      req_size_o,
  output logic [31:0]                req_wdata_o
);
  import vga_fe_pkg::*;
  initial begin
    req_valid_o = 1'b0;
    req_io_o    = 1'b0;
    req_write_o = 1'b0;
    req_addr_o  = 32'h0000_0000;
    req_size_o  = SZ_BYTE;
    req_wdata_o = 32'h0000_0000;
  end
  // strictly one access at a time: the next is never offered before the answer or a 40-cycle timeout
  task automatic access(input logic io, input logic wr, input logic [31:0] a,
                        input acc_size_t sz, input logic [31:0] wd,
                        output logic got_ack, output logic got_pass);
    int n;
    @(negedge sys_clk_i);
    req_io_o    = io;
    req_write_o = wr;
    req_addr_o  = a;
    req_size_o  = sz;
    req_wdata_o = wd;
    req_valid_o = 1'b1;
    @(negedge sys_clk_i);
    req_valid_o = 1'b0;
    n = 0;
    while (!ack_i && !pass_i && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
    got_ack  = ack_i;
    got_pass = pass_i;
    // the cycle after an answer is not idle yet
    @(negedge sys_clk_i);
  endtask
endmodule

/* verification/vga_front_end_bench.sv */
`timescale 1ns/1ns
module vga_front_end_bench;
  import vga_fe_pkg::*;
  logic        sys_clk_i, arst_n_i, trap_mem_i, trap_io_i, mgmt_ack_i, ce;
  logic        req_valid, req_io, req_write, busy, ack, pass, irq, got_ack, got_pass;
  logic [31:0] req_addr, req_wdata, rdata, pixels;
  acc_size_t   req_size;
  logic [7:0]  misc, mmode, gmisc, rmap, d;
  logic [3:0]  mask;
  logic [31:0] fb [int];
  logic [31:0] addrs [8];
  int          failures, n_tests, cyc;
  time         t0, t1;

  vga_front_end dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(ce),
    .req_valid_i(req_valid), .req_io_i(req_io), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_size_i(req_size), .req_wdata_i(req_wdata),
    .trap_mem_i(trap_mem_i), .trap_io_i(trap_io_i), .mgmt_ack_i(mgmt_ack_i),
    .busy_o(busy), .ack_o(ack), .pass_o(pass), .rdata_o(rdata),
    .mgmt_interrupt_request_o(irq), .pixels_o(pixels));
  vga_host_model u_host (.sys_clk_i(sys_clk_i), .ack_i(ack), .pass_i(pass),
    .req_valid_o(req_valid), .req_io_o(req_io), .req_write_o(req_write),
    .req_addr_o(req_addr), .req_size_o(req_size), .req_wdata_o(req_wdata));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under 3000 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // for reads, dv is the expected byte
  task automatic io(input logic wr, input logic [15:0] p, input logic [7:0] dv);
    u_host.access(1'b1, wr, {16'h0000, p}, SZ_BYTE, {24'h00_0000, dv}, got_ack, got_pass);
    check("io ack", 32'h1, {31'h0, got_ack});
    if (wr && p == IO_MISC_WR)
      misc = dv;
    if (!wr)
      check("io rdata", {24'h0, dv}, {24'h0, rdata[7:0]});
  endtask

  task automatic set_reg(input logic [15:0] p, input logic [7:0] idx, input logic [7:0] dv);
    io(1'b1, p, idx);
    io(1'b1, p + 16'h0001, dv);
    if (p == IO_SEQ_IDX && idx == SEQ_MAP_MASK) mask = dv[3:0];
    if (p == IO_SEQ_IDX && idx == SEQ_MEM_MODE) mmode = dv;
    if (p == IO_GFX_IDX && idx == GFX_READ_MAP) rmap = dv;
    if (p == IO_GFX_IDX && idx == GFX_MISC) gmisc = dv;
  endtask

  task automatic mem(input logic wr, input logic [31:0] a, input acc_size_t sz);
    logic [31:0] wd, ai, w, e, m, px;
    logic [15:0] wa;
    logic [3:0]  ln;
    logic [1:0]  pl;
    logic        hit;
    int          k;
    wd = $urandom();
    e = 32'h0;
    k = (sz == SZ_BYTE) ? 1 : (sz == SZ_WORD) ? 2 : 4;
    case (gmisc[3:2])
      2'd1: hit = a >= EGA_BASE && a <= EGA_LAST;
      2'd2: hit = a >= MDA_BASE && a <= MDA_LAST;
      2'd3: hit = a >= CGA_BASE && a <= CGA_LAST;
      default: hit = a >= WIN_BASE && a <= WIN_LAST;
    endcase
    u_host.access(1'b0, wr, a, sz, wd, got_ack, got_pass);
    check("pass", {31'h0, !hit}, {31'h0, got_pass});
    if (hit) begin
      for (int i = 0; i < k; i++) begin
        ai = a + i;
        wa = ai[15:0];
        ln = mask;
        pl = rmap[1:0];
        if (mmode[MMODE_CHAIN4_BIT]) begin
          wa = {ai[15:2], 2'b00};
          ln = mask & (4'h1 << ai[1:0]);
          pl = ai[1:0];
        end else if (!mmode[MMODE_OEDIS_BIT]) begin
          wa = {ai[15:1], misc[MISC_PAGE_BIT]};
          ln = mask & (ai[0] ? 4'hA : 4'h5);
          pl = {rmap[1], ai[0]};
        end
        w = fb.exists(wa) ? fb[wa] : 32'hxxxx_xxxx;
        for (int l = 0; l < 4; l++)
          if (wr && ln[l]) w[8*l +: 8] = wd[8*i +: 8];
        fb[wa] = w;
        e[8*i +: 8] = w[8*pl +: 8];
      end
      check("ack", 32'h1, {31'h0, got_ack});
      if (!wr) begin
        m = (k == 4) ? 32'hFFFF_FFFF : (32'h1 << (8 * k)) - 32'h1;
        check("rdata", e & m, rdata & m);
        for (int i = 0; i < 8; i++)
          for (int j = 0; j < 4; j++) px[4*i+j] = w[8*j+7-i];
        check("pixels", px, pixels);
      end
    end
  endtask

  initial begin
    arst_n_i = 1'b0;
    ce = 1'b1;
    trap_mem_i = 1'b0;
    trap_io_i = 1'b0;
    mgmt_ack_i = 1'b0;
    misc = MISC_RESET;
    mmode = MMODE_RESET;
    gmisc = GMISC_RESET;
    rmap = 8'h00;
    mask = MASK_RESET;
    addrs = '{32'h9_FFFF, 32'hA_0000, 32'hA_FFFF, 32'hB_0000,
              32'hB_7FFF, 32'hB_8000, 32'hB_FFFF, 32'hC_0000};
    void'($urandom(85));
    repeat (20) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    io(1'b0, IO_MISC_RD, MISC_RESET);
    io(1'b0, 16'h03AF, IO_IDLE_DATA);
    io(1'b0, 16'h03E0, IO_IDLE_DATA);
    $display("test io decode done");
    for (int i = 0; i < 17; i++) mem(1'b1, WIN_BASE + 4 * i, SZ_DWORD);
    for (int r = 0; r < 4; r++) begin
      set_reg(IO_GFX_IDX, GFX_READ_MAP, r[7:0]);
      mem(1'b0, WIN_BASE + 4 * $urandom_range(15), SZ_DWORD);
      mem(1'b0, WIN_BASE + 1, SZ_WORD);
    end
    set_reg(IO_GFX_IDX, GFX_READ_MAP, 8'h00);
    $display("test split access done");
    for (int s = 0; s < 4; s++) begin
      set_reg(IO_GFX_IDX, GFX_MISC, s[7:0] << GMISC_MAP_LSB);
      foreach (addrs[n]) mem(1'b1, addrs[n], SZ_BYTE);
    end
    set_reg(IO_GFX_IDX, GFX_MISC, GMISC_RESET);
    $display("test mapping done");
    set_reg(IO_SEQ_IDX, SEQ_MAP_MASK, 8'h05);
    mem(1'b1, WIN_BASE + 5, SZ_WORD);
    set_reg(IO_SEQ_IDX, SEQ_MAP_MASK, 8'h0F);
    io(1'b1, IO_MISC_WR, 8'h20);
    set_reg(IO_SEQ_IDX, SEQ_MEM_MODE, 8'h00);
    mem(1'b1, WIN_BASE + 8, SZ_DWORD);
    for (int r = 0; r < 4; r++) begin
      set_reg(IO_GFX_IDX, GFX_READ_MAP, r[7:0]);
      mem(1'b0, WIN_BASE + 8, SZ_DWORD);
      mem(1'b0, WIN_BASE + 5, SZ_WORD);
    end
    set_reg(IO_SEQ_IDX, SEQ_MEM_MODE, 8'h08);
    mem(1'b1, WIN_BASE + 16, SZ_DWORD);
    mem(1'b0, WIN_BASE + 16, SZ_DWORD);
    set_reg(IO_SEQ_IDX, SEQ_MEM_MODE, MMODE_RESET);
    $display("test plane modes done");
    d = $urandom();
    io(1'b1, IO_MISC_WR, 8'h00);
    set_reg(IO_CRT_IDX_M, 8'h0C, d);
    io(1'b0, IO_CRT_DAT_M, d);
    io(1'b0, IO_CRT_DAT_C, IO_IDLE_DATA);
    io(1'b1, IO_MISC_WR, 8'h01);
    io(1'b0, IO_CRT_DAT_M, IO_IDLE_DATA);
    set_reg(IO_CRT_IDX_C, 8'h0E, ~d);
    io(1'b0, IO_CRT_DAT_C, ~d);
    $display("test dual location done");
    // a frozen clock enable must stretch the access by exactly the frozen cycles
    t0 = $time;
    mem(1'b0, WIN_BASE + 1, SZ_WORD);
    t1 = $time - t0;
    t0 = $time;
    fork
      mem(1'b0, WIN_BASE + 1, SZ_WORD);
      begin
        repeat (2) @(negedge sys_clk_i);
        ce = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        ce = 1'b1;
      end
    join
    check("frozen cycles", 32'd3, 32'(($time - t0 - t1) / 8));
    $display("test clock enable done");
    for (int t = 0; t < 2; t++) begin
      trap_mem_i = (t == 0);
      trap_io_i = (t == 1);
      if (t == 0)
        mem(1'b1, WIN_BASE, SZ_BYTE);
      else
        io(1'b0, IO_MISC_RD, 8'h01);
      check("mgmt set", 32'h1, {31'h0, irq});
      trap_mem_i = 1'b0;
      trap_io_i = 1'b0;
      mgmt_ack_i = 1'b1;
      @(negedge sys_clk_i);
      mgmt_ack_i = 1'b0;
      @(negedge sys_clk_i);
      check("mgmt clear", 32'h0, {31'h0, irq});
    end
    $display("test management request done");
    close_out();
  end
endmodule
